// [core/output_format_control.sv]
// output format configuration register and effective-setting decode
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "fmt_defines.svh"

// Summary of operation
// - bit1 picks DDR/SDR, two-lane only
// - capture edge matters only with SDR
// - bit4 0 falling, 1 rising capture
// - bit5 enables 3.5dB coarse gain
// - bit6 0 msb first, 1 lsb first
// - bit7 byte or bit split, two-lane
// - pins can set every format function
// - bit10 set: register overrides pins
// - soft reset restores defaults, self-clears
module output_format_control (
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // register port
   input  wire logic [`ADDR_W-1:0]      reg_addr,
   input  wire logic [`DATA_W-1:0]      reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [`DATA_W-1:0]      reg_rdata,
   // parallel configuration pins
   input  wire logic                    pin_two_lane,
   input  wire logic                    pin_sdr,
   input  wire logic                    pin_ser14,
   input  wire logic                    pin_rise_capture,
   input  wire logic                    pin_coarse_gain,
   input  wire logic                    pin_lsb_first,
   input  wire logic                    pin_bit_wise,
   // effective settings
   output fmt_pkg::lane_mode_t          lane_mode,
   output fmt_pkg::clk_rate_t           clk_rate,
   output logic                         rise_capture,
   output logic                         coarse_gain_on,
   output logic                         lsb_first,
   output fmt_pkg::split_t              lane_split,
   output logic      [3:0]              frame_bits
);
   import fmt_pkg::*;

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   localparam int NUM_FIELDS = 7;

   // every field must sit inside the register word
   if (`BIT_OVERRIDE >= `DATA_W) begin : g_chk_override
      $error("override bit lies outside the register word");
   end
   if (`BIT_SOFT_RESET >= `DATA_W) begin : g_chk_soft_reset
      $error("soft reset bit lies outside the register word");
   end
   if (`BIT_BIT_WISE >= `DATA_W) begin : g_chk_fields
      $error("format fields lie outside the register word");
   end
   // the format offset must be reachable on the address port
   if (`OFF_FORMAT >= (1 << `ADDR_W)) begin : g_chk_offset
      $error("format offset does not fit the address port");
   end
   // the two frame lengths must stay distinguishable downstream
   if (`FRAME_BITS_12 == `FRAME_BITS_14) begin : g_chk_frame
      $error("frame length codes must differ");
   end

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   logic hit_format;
   logic hit_reset;
   logic wr_format;
   logic soft_reset;

   assign hit_format = reg_addr == `OFF_FORMAT;
   assign hit_reset  = reg_addr == `OFF_RESET_CTRL;
   assign wr_format  = reg_wr & hit_format;
   // the reset bit is write-only and self-clears, so it is never stored
   assign soft_reset = reg_wr & hit_reset & reg_wdata[`BIT_SOFT_RESET];

   // ----------------------------------------
   // format register
   // ----------------------------------------
   logic [`DATA_W-1:0] format_reg;
   logic [`DATA_W-1:0] next_format_reg;

   always_comb begin
      next_format_reg = format_reg;
      if (soft_reset) begin
         next_format_reg = `FORMAT_RESET;
      end else if (wr_format) begin
         // bits 3, 8 and 9 stay zero
         next_format_reg = reg_wdata & `FORMAT_WMASK;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         format_reg <= `FORMAT_RESET;
      end else begin
         format_reg <= next_format_reg;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   logic [`DATA_W-1:0] next_rdata;

   // unmapped offsets, the reset offset included, read as zero
   always_comb begin
      next_rdata = '0;
      if (reg_rd && hit_format) begin
         next_rdata = format_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // source selection
   // ----------------------------------------
   logic [NUM_FIELDS-1:0] reg_fields;
   logic [NUM_FIELDS-1:0] pin_fields;
   logic [NUM_FIELDS-1:0] eff;

   assign reg_fields = {format_reg[`BIT_BIT_WISE],
                        format_reg[`BIT_LSB_FIRST],
                        format_reg[`BIT_COARSE_GAIN],
                        format_reg[`BIT_RISE_CAPTURE],
                        format_reg[`BIT_SER14],
                        format_reg[`BIT_SDR],
                        format_reg[`BIT_TWO_LANE]};
   assign pin_fields = {pin_bit_wise, pin_lsb_first, pin_coarse_gain,
                        pin_rise_capture, pin_ser14, pin_sdr,
                        pin_two_lane};

   fmt_select #(
      .WIDTH (NUM_FIELDS)
   ) u_select (
      .use_reg (format_reg[`BIT_OVERRIDE]),
      .reg_val (reg_fields),
      .pin_val (pin_fields),
      .sel_val (eff)
   );

   // ----------------------------------------
   // effective fields
   // ----------------------------------------
   logic eff_two_lane;
   logic eff_sdr;
   logic eff_ser14;
   logic eff_rise_capture;
   logic eff_coarse_gain;
   logic eff_lsb_first;
   logic eff_bit_wise;

   assign eff_two_lane     = eff[0];
   assign eff_sdr          = eff[1];
   assign eff_ser14        = eff[2];
   assign eff_rise_capture = eff[3];
   assign eff_coarse_gain  = eff[4];
   assign eff_lsb_first    = eff[5];
   assign eff_bit_wise     = eff[6];

   // ----------------------------------------
   // effective decode, registered
   // ----------------------------------------
   logic       sdr;
   lane_mode_t next_lane_mode;
   clk_rate_t  next_clk_rate;
   split_t     next_lane_split;
   logic       next_rise_capture;
   logic       next_coarse_gain_on;
   logic       next_lsb_first;
   logic [3:0] next_frame_bits;

   always_comb begin
      // one lane always runs DDR
      sdr                 = eff_two_lane & eff_sdr;
      next_lane_mode      = eff_two_lane ? LANE_TWO : LANE_ONE;
      next_clk_rate       = sdr ? CLK_SDR : CLK_DDR;
      // DDR keeps the default falling-edge capture
      next_rise_capture   = sdr & eff_rise_capture;
      next_coarse_gain_on = eff_coarse_gain;
      next_lsb_first      = eff_lsb_first;
      next_frame_bits     = eff_ser14 ? `FRAME_BITS_14
                                      : `FRAME_BITS_12;
      // bit-wise split only exists with two lanes
      next_lane_split     = (eff_two_lane & eff_bit_wise) ? SPLIT_BIT
                                                          : SPLIT_BYTE;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lane_mode      <= LANE_ONE;
         clk_rate       <= CLK_DDR;
         rise_capture   <= 1'b0;
         coarse_gain_on <= 1'b0;
         lsb_first      <= 1'b0;
         lane_split     <= SPLIT_BYTE;
         frame_bits     <= `FRAME_BITS_12;
      end else begin
         lane_mode      <= next_lane_mode;
         clk_rate       <= next_clk_rate;
         rise_capture   <= next_rise_capture;
         coarse_gain_on <= next_coarse_gain_on;
         lsb_first      <= next_lsb_first;
         lane_split     <= next_lane_split;
         frame_bits     <= next_frame_bits;
      end
   end
endmodule

// [core/fmt_defines.svh]
// register map, field positions and reset values of the output format block
`ifndef FMT_DEFINES_SVH
`define FMT_DEFINES_SVH

`define ADDR_W            5
`define DATA_W            11
`define OFF_FORMAT        5'h0d
`define OFF_RESET_CTRL    5'h00
`define BIT_TWO_LANE      0
`define BIT_SDR           1
`define BIT_SER14         2
`define BIT_RISE_CAPTURE  4
`define BIT_COARSE_GAIN   5
`define BIT_LSB_FIRST     6
`define BIT_BIT_WISE      7
`define BIT_OVERRIDE      10
`define BIT_SOFT_RESET    10
`define FORMAT_RESET      11'h000
`define FORMAT_WMASK      11'h4f7
`define FRAME_BITS_12     4'hc
`define FRAME_BITS_14     4'he

`endif

// [core/fmt_pkg.sv]
// types shared by the output format block
package fmt_pkg;
   typedef enum logic [0:0] {
      LANE_ONE = 1'b0,
      LANE_TWO = 1'b1
   } lane_mode_t;
   typedef enum logic [0:0] {
      CLK_DDR = 1'b0,
      CLK_SDR = 1'b1
   } clk_rate_t;
   typedef enum logic [0:0] {
      SPLIT_BYTE = 1'b0,
      SPLIT_BIT  = 1'b1
   } split_t;
endpackage

// [core/fmt_select.sv]
// picks register or pin source for each format setting
`timescale 1ns/100ps
module fmt_select #(
   parameter int WIDTH = 8
) (
   // choice
   input  wire logic             use_reg,
   // sources
   input  wire logic [WIDTH-1:0] reg_val,
   input  wire logic [WIDTH-1:0] pin_val,
   // result
   output logic      [WIDTH-1:0] sel_val
);
   // refused at elaboration, a zero-width select has no meaning
   if (WIDTH < 1) begin : g_chk_width
      $error("fmt_select: WIDTH must be positive");
   end
   assign sel_val = use_reg ? reg_val : pin_val;
endmodule

// [dv/output_format_control_assertions.sv]
// port-level checks of the output format block
`timescale 1ns/100ps
`include "fmt_defines.svh"
module fmt_chk
   import fmt_pkg::*;
(
   // clock, reset, register port
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [4:0]  reg_addr,
   input wire logic [10:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [10:0] reg_rdata,
   // pins
   input wire logic        pin_two_lane,
   input wire logic        pin_sdr,
   input wire logic        pin_ser14,
   input wire logic        pin_rise_capture,
   input wire logic        pin_coarse_gain,
   input wire logic        pin_lsb_first,
   input wire logic        pin_bit_wise,
   // settings
   input wire lane_mode_t  lane_mode,
   input wire clk_rate_t   clk_rate,
   input wire logic        rise_capture,
   input wire logic        coarse_gain_on,
   input wire logic        lsb_first,
   input wire split_t      lane_split,
   input wire logic [3:0]  frame_bits
);
   logic [10:0] fmt, next_fmt;
   logic [6:0]  src, s1, s2;
   logic        r1, r2, steady;
   assign src = fmt[10] ? {fmt[7:4], fmt[2:0]} : {pin_bit_wise,
      pin_lsb_first, pin_coarse_gain, pin_rise_capture, pin_ser14,
      pin_sdr, pin_two_lane};
   // settle time covers both the register and the output flop
   assign steady = src == s1 && s1 == s2 && r1 && r2;
   always_comb begin
      next_fmt = fmt;
      if (reg_wr && reg_addr == `OFF_FORMAT)
         next_fmt = reg_wdata & `FORMAT_WMASK;
      else if (reg_wr && reg_addr == `OFF_RESET_CTRL && reg_wdata[10])
         next_fmt = '0;
      if (!rst_n)
         next_fmt = '0;
   end
   always_ff @(posedge clk_sys) begin
      fmt <= next_fmt;
      s1 <= src;
      s2 <= s1;
      r1 <= rst_n;
      r2 <= r1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_lane_src: assert property (steady |-> lane_mode == src[0])
      else $error("lane mode differs from source");
   a_rate_src: assert property (steady |-> clk_rate == &src[1:0])
      else $error("bit clock rate wrong");
   a_edge_src: assert property (steady |->
      rise_capture == (src[3] & src[1] & src[0]))
      else $error("capture edge wrong");
   a_gain_src: assert property (steady |-> coarse_gain_on == src[4])
      else $error("coarse gain wrong");
   a_order_src: assert property (steady |-> lsb_first == src[5])
      else $error("bit order wrong");
   a_split_src: assert property (steady |->
      lane_split == (src[6] & src[0]))
      else $error("lane split wrong");
   a_frame_src: assert property (steady |->
      frame_bits == (src[2] ? `FRAME_BITS_14 : `FRAME_BITS_12))
      else $error("frame length wrong");
   a_read_back: assert property (reg_rd && reg_addr == `OFF_FORMAT |=>
      reg_rdata == $past(fmt))
      else $error("format read data wrong");
endmodule
bind output_format_control fmt_chk chk_u (.*);

// [dv/output_format_control_test.sv]
// self-checking bench of the output format block
`timescale 1ns/100ps
module output_format_control_test;
   import fmt_pkg::*;
   logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
   logic [4:0] reg_addr = '0;
   logic [10:0] reg_wdata = '0, reg_rdata;
   logic pin_two_lane = 1, pin_sdr = 1, pin_ser14 = 1, pin_bit_wise = 1;
   logic pin_rise_capture = 1, pin_coarse_gain = 1, pin_lsb_first = 1;
   lane_mode_t lane_mode;
   clk_rate_t clk_rate;
   split_t lane_split;
   logic rise_capture, coarse_gain_on, lsb_first;
   logic [3:0] frame_bits;
   int mismatches = 0, num_checks = 0;
   always #4 clk_sys = ~clk_sys;
   output_format_control dut_u (.*);
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [10:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [10:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // settings packed as lane, rate, edge, gain, order, split, frame
   task automatic outs(input logic [9:0] e);
      repeat (4) @(posedge clk_sys);
      #1 chk({1'b0, lane_mode, clk_rate, rise_capture, coarse_gain_on,
         lsb_first, lane_split, frame_bits}, {1'b0, e});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      outs(10'h3fe);
      wr(5'h0d, 11'h400);
      outs(10'h00c);
      wr(5'h0d, 11'h7ff);
      rd(5'h0d, 11'h4f7);
      wr(5'h0d, 11'h4f6);
      outs(10'h06e);
      wr(5'h0d, 11'h403);
      outs(10'h30c);
      wr(5'h0d, 11'h411);
      outs(10'h20c);
      wr(5'h0d, 11'h413);
      outs(10'h38c);
      wr(5'h00, 11'h3ff);
      rd(5'h0d, 11'h413);
      wr(5'h00, 11'h400);
      rd(5'h0d, 11'h000);
      outs(10'h3fe);
      @(posedge clk_sys);
      {pin_bit_wise, pin_lsb_first, pin_coarse_gain, pin_rise_capture,
         pin_ser14, pin_sdr, pin_two_lane} <= 7'h05;
      outs(10'h20e);
      rd(5'h01, 11'h000);
      rd(5'h00, 11'h000);
      finish_test;
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      mismatches++;
      finish_test;
   end
endmodule
